// [hw/dsc_regs.sv]
// Debug state capture register group of a processor tile
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Cell oscillator count reads in bits 15:0, upper half reads zero.
// - Wire oscillator count at index 0x0A, 16 bits, read-only, upper zero.
// - Oscillator counts survive system reset; only power-on clears them.
// - Memory size word reads RAM bytes in bits 31:2, bits 1:0 zero.
// - Debug entry copies saved status into index 0x10 bits 10:0.
// - Status bits 0-4 hold event, irq, setup, handler, kernel flags; 5 reserved.
// - Status bit 7 is fast issue, bit 6 paused waiting.
// - Bit 8 read-only dual issue, bit 9 kernel-entry mode, bit 10 space id.
// - Debug entry captures full 32-bit saved program counter at 0x11.
// - Debug entry captures full 32-bit saved stack pointer at 0x12.
// - Debugger writes target thread into 8-bit field at 0x13.
// - Debugger writes register number into 5-bit field at 0x14.
// - Cause field resets to zero and encodes what triggered entry.
// - Bits 17:16 hold breakpoint index, zero for host and debug call.
// - Several simultaneous hits record the lowest-numbered one.
// - Bits 15:8 hold causing thread, zero for host request.
// - Data watch stores address, resource watch stores resource id, at 0x16.
module dsc_regs #(
	parameter int          ADDR_W         = 10,
	parameter logic [31:0] MEM_SIZE_BYTES = 32'h0001_0000
) (
	input  wire logic                      I_CLOCK,
	input  wire logic                      I_RST_B,
	input  wire logic                      I_POR_B,
	// Register port
	input  wire logic [ADDR_W-1:0]         I_ADDR,
	input  wire logic [31:0]               I_WDATA,
	input  wire logic                      I_WR,
	input  wire logic                      I_RD,
	output logic [31:0]                    O_RDATA,
	// Ring oscillator pins
	input  wire logic                      I_OSC_CELL,
	input  wire logic                      I_OSC_WIRE,
	// Core state at debug entry
	input  wire logic                      I_DEBUG_MODE,
	input  wire logic                      I_DEBUG_ENTRY,
	input  wire logic [dsc_pkg::SSR_W-1:0] I_SAVED_STATUS,
	input  wire logic [31:0]               I_SAVED_PC,
	input  wire logic [31:0]               I_SAVED_SP,
	input  wire logic                      I_HOST_REQ,
	input  wire logic                      I_DEBUG_CALL_INSTRUCTION,
	input  wire logic [3:0]                I_IBRK_HIT,
	input  wire logic [3:0]                I_DWATCH_HIT,
	input  wire logic [3:0]                I_RWATCH_HIT,
	input  wire logic [7:0]                I_CAUSE_THREAD,
	input  wire logic [31:0]               I_WATCH_ADDR,
	input  wire logic [31:0]               I_RESOURCE_ID,
	// Register-read instruction
	input  wire logic                      I_GETREG_EXEC,
	input  wire logic                      I_GETREG_ACK,
	input  wire logic [31:0]               I_GETREG_DATA,
	output logic                           O_GETREG_REQ,
	output logic [7:0]                     O_GETREG_THREAD,
	output logic [4:0]                     O_GETREG_REG,
	output logic                           O_GETREG_DONE,
	output logic [31:0]                    O_GETREG_RESULT
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int IDX_W = ADDR_W - 2;

	logic [dsc_pkg::OSC_W-1:0]    cnt_cell;
	logic [dsc_pkg::OSC_W-1:0]    cnt_wire;

	logic [dsc_pkg::SSR_W-1:0]    saved_sr_ff;
	logic [31:0]                  saved_pc_ff;
	logic [31:0]                  saved_sp_ff;
	logic [dsc_pkg::THREAD_W-1:0] thread_sel_ff;
	logic [dsc_pkg::REGSEL_W-1:0] reg_sel_ff;
	logic [dsc_pkg::CAUSE_W-1:0]  cause_ff;
	logic [dsc_pkg::THREAD_W-1:0] cause_thread_ff;
	logic [1:0]                   bkpt_idx_ff;
	logic [31:0]                  debug_data_ff;
	logic [31:0]                  rdata_ff;

	dsc_pkg::dsc_gr_state_type    gr_state_ff;
	dsc_pkg::dsc_gr_state_type    nxt_gr_state;
	logic                         gr_req_ff;
	logic                         gr_done_ff;
	logic [31:0]                  gr_result_ff;

	logic                         aligned;
	logic [7:0]                   idx;
	logic                         dbg_wr;
	logic                         wr_sr;
	logic                         wr_pc;
	logic                         wr_sp;
	logic                         wr_tsel;
	logic                         wr_rsel;
	logic                         wr_cause;
	logic                         wr_data;

	dsc_pkg::dsc_cause_type       nxt_cause;
	logic [1:0]                   nxt_bkpt_idx;
	logic [3:0]                   hit_vec;
	logic [31:0]                  rd_mux;

	// ------------------------------------------------------------
	// Ring oscillator counters
	// ------------------------------------------------------------
	// power-on only
	dsc_osc_count #(
		.WIDTH     (dsc_pkg::OSC_W)
	) u_cnt_cell (
		.i_clock   (I_CLOCK),
		.i_por_b   (I_POR_B),
		.i_osc_pin (I_OSC_CELL),
		.o_count   (cnt_cell)
	);

	dsc_osc_count #(
		.WIDTH     (dsc_pkg::OSC_W)
	) u_cnt_wire (
		.i_clock   (I_CLOCK),
		.i_por_b   (I_POR_B),
		.i_osc_pin (I_OSC_WIRE),
		.o_count   (cnt_wire)
	);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Word index; misaligned addresses decode as unmapped
	assign aligned = (I_ADDR[1:0] == 2'h0);
	assign idx     = 8'(I_ADDR[ADDR_W-1:2]);

	assign dbg_wr   = I_WR && aligned && I_DEBUG_MODE;
	assign wr_sr    = dbg_wr && (idx == dsc_pkg::IDX_SAVED_SR);
	assign wr_pc    = dbg_wr && (idx == dsc_pkg::IDX_SAVED_PC);
	assign wr_sp    = dbg_wr && (idx == dsc_pkg::IDX_SAVED_SP);
	assign wr_tsel  = dbg_wr && (idx == dsc_pkg::IDX_THREAD_SEL);
	assign wr_rsel  = dbg_wr && (idx == dsc_pkg::IDX_REG_SEL);
	assign wr_cause = dbg_wr && (idx == dsc_pkg::IDX_ENTRY_CAUSE);
	assign wr_data  = dbg_wr && (idx == dsc_pkg::IDX_DEBUG_DATA);

	// ------------------------------------------------------------
	// Cause decode
	// ------------------------------------------------------------
	// Fixed priority: host, call, instruction, data, resource
	always_comb begin
		nxt_cause = dsc_pkg::CAUSE_NONE;
		hit_vec   = 4'h0;
		if (I_HOST_REQ) begin
			nxt_cause = dsc_pkg::CAUSE_HOST;
		end else if (I_DEBUG_CALL_INSTRUCTION) begin
			nxt_cause = dsc_pkg::CAUSE_DEBUG_CALL_INSTRUCTION;
		end else if (|I_IBRK_HIT) begin
			nxt_cause = dsc_pkg::CAUSE_IBRK;
			hit_vec   = I_IBRK_HIT;
		end else if (|I_DWATCH_HIT) begin
			nxt_cause = dsc_pkg::CAUSE_DWATCH;
			hit_vec   = I_DWATCH_HIT;
		end else if (|I_RWATCH_HIT) begin
			nxt_cause = dsc_pkg::CAUSE_RWATCH;
			hit_vec   = I_RWATCH_HIT;
		end
	end

	always_comb begin
		nxt_bkpt_idx = 2'h0;
		for (int i = dsc_pkg::NUM_BKPT - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				nxt_bkpt_idx = 2'(i);
			end
		end
	end

	// ------------------------------------------------------------
	// Captured thread state
	// ------------------------------------------------------------
	// Capture beats a same-cycle software write, so entry state is never lost
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			saved_sr_ff <= dsc_pkg::SSR_W'(dsc_pkg::RST_WORD);
		end else if (I_DEBUG_ENTRY) begin
			saved_sr_ff <= I_SAVED_STATUS;
			saved_sr_ff[dsc_pkg::SSR_RSVD_BIT] <= 1'b0;
		end else if (wr_sr) begin
			saved_sr_ff[4:0] <= I_WDATA[4:0];
			saved_sr_ff[7:6] <= I_WDATA[7:6];
			// bit 8 kept, 9 and 10 writable
			saved_sr_ff[10:9] <= I_WDATA[10:9];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			saved_pc_ff <= dsc_pkg::RST_WORD;
		end else if (I_DEBUG_ENTRY) begin
			saved_pc_ff <= I_SAVED_PC;
		end else if (wr_pc) begin
			saved_pc_ff <= I_WDATA;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			saved_sp_ff <= dsc_pkg::RST_WORD;
		end else if (I_DEBUG_ENTRY) begin
			saved_sp_ff <= I_SAVED_SP;
		end else if (wr_sp) begin
			saved_sp_ff <= I_WDATA;
		end
	end

	// ------------------------------------------------------------
	// Register-read operands
	// ------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			thread_sel_ff <= dsc_pkg::THREAD_W'(dsc_pkg::RST_WORD);
			reg_sel_ff    <= dsc_pkg::REGSEL_W'(dsc_pkg::RST_WORD);
		end else begin
			if (wr_tsel) begin
				thread_sel_ff <= I_WDATA[dsc_pkg::THREAD_W-1:0];
			end
			if (wr_rsel) begin
				reg_sel_ff <= I_WDATA[dsc_pkg::REGSEL_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Entry cause and debug data
	// ------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			cause_ff        <= dsc_pkg::CAUSE_NONE;
			cause_thread_ff <= dsc_pkg::THREAD_W'(dsc_pkg::RST_WORD);
			bkpt_idx_ff     <= dsc_pkg::BKPT_IDX_W'(dsc_pkg::RST_WORD);
		end else if (I_DEBUG_ENTRY) begin
			cause_ff        <= nxt_cause;
			cause_thread_ff <= I_HOST_REQ ? 8'h00 : I_CAUSE_THREAD;
			bkpt_idx_ff     <= nxt_bkpt_idx;
		end else if (wr_cause) begin
			cause_ff        <= I_WDATA[dsc_pkg::CAUSE_W-1:0];
			cause_thread_ff <= I_WDATA[dsc_pkg::CAUSE_THREAD_LSB +: dsc_pkg::THREAD_W];
			bkpt_idx_ff     <= I_WDATA[dsc_pkg::BKPT_IDX_LSB +: dsc_pkg::BKPT_IDX_W];
		end
	end

	// Other causes leave the data word untouched
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			debug_data_ff <= dsc_pkg::RST_WORD;
		end else if (I_DEBUG_ENTRY && nxt_cause == dsc_pkg::CAUSE_DWATCH) begin
			debug_data_ff <= I_WATCH_ADDR;
		end else if (I_DEBUG_ENTRY && nxt_cause == dsc_pkg::CAUSE_RWATCH) begin
			debug_data_ff <= I_RESOURCE_ID;
		end else if (wr_data) begin
			debug_data_ff <= I_WDATA;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Reserved bits and unmapped words read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (idx)
			dsc_pkg::IDX_RING_CELL: begin
				rd_mux[dsc_pkg::OSC_W-1:0] = cnt_cell;
			end
			dsc_pkg::IDX_RING_WIRE: begin
				rd_mux[dsc_pkg::OSC_W-1:0] = cnt_wire;
			end
			dsc_pkg::IDX_MEM_SIZE: begin
				rd_mux[31:dsc_pkg::MEMSZ_LSB] = MEM_SIZE_BYTES[31:dsc_pkg::MEMSZ_LSB];
			end
			dsc_pkg::IDX_SAVED_SR: begin
				rd_mux[dsc_pkg::SSR_W-1:0] = saved_sr_ff;
			end
			dsc_pkg::IDX_SAVED_PC: begin
				rd_mux = saved_pc_ff;
			end
			dsc_pkg::IDX_SAVED_SP: begin
				rd_mux = saved_sp_ff;
			end
			dsc_pkg::IDX_THREAD_SEL: begin
				rd_mux[dsc_pkg::THREAD_W-1:0] = thread_sel_ff;
			end
			dsc_pkg::IDX_REG_SEL: begin
				rd_mux[dsc_pkg::REGSEL_W-1:0] = reg_sel_ff;
			end
			dsc_pkg::IDX_ENTRY_CAUSE: begin
				rd_mux[dsc_pkg::CAUSE_W-1:0] = cause_ff;
				rd_mux[dsc_pkg::CAUSE_THREAD_LSB +: dsc_pkg::THREAD_W] = cause_thread_ff;
				rd_mux[dsc_pkg::BKPT_IDX_LSB +: dsc_pkg::BKPT_IDX_W] = bkpt_idx_ff;
			end
			dsc_pkg::IDX_DEBUG_DATA: begin
				rd_mux = debug_data_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			rdata_ff <= dsc_pkg::RST_WORD;
		end else if (I_RD && aligned) begin
			rdata_ff <= rd_mux;
		end else begin
			rdata_ff <= dsc_pkg::RST_WORD;
		end
	end

	// ------------------------------------------------------------
	// Register-read instruction sequencer
	// ------------------------------------------------------------
	// One fetch at a time; a new execute while waiting is dropped
	always_comb begin
		nxt_gr_state = gr_state_ff;
		case (gr_state_ff)
			dsc_pkg::GR_IDLE: begin
				if (I_GETREG_EXEC) begin
					nxt_gr_state = dsc_pkg::GR_WAIT;
				end
			end
			dsc_pkg::GR_WAIT: begin
				if (I_GETREG_ACK) begin
					nxt_gr_state = dsc_pkg::GR_IDLE;
				end
			end
			default: begin
				nxt_gr_state = dsc_pkg::GR_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			gr_state_ff <= dsc_pkg::GR_IDLE;
		end else begin
			gr_state_ff <= nxt_gr_state;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) begin
			gr_req_ff    <= 1'b0;
			gr_done_ff   <= 1'b0;
			gr_result_ff <= dsc_pkg::RST_WORD;
		end else begin
			gr_req_ff  <= (gr_state_ff == dsc_pkg::GR_IDLE) && I_GETREG_EXEC;
			gr_done_ff <= (gr_state_ff == dsc_pkg::GR_WAIT) && I_GETREG_ACK;
			if ((gr_state_ff == dsc_pkg::GR_WAIT) && I_GETREG_ACK) begin
				gr_result_ff <= I_GETREG_DATA;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Operand fields drive the core directly from their flops
	assign O_RDATA         = rdata_ff;
	assign O_GETREG_REQ    = gr_req_ff;
	assign O_GETREG_THREAD = thread_sel_ff;
	assign O_GETREG_REG    = reg_sel_ff;
	assign O_GETREG_DONE   = gr_done_ff;
	assign O_GETREG_RESULT = gr_result_ff;

endmodule
`default_nettype wire

// [hw/dsc_pkg.sv]
// Constants and types for the debug state capture register group
package dsc_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_RING_CELL   = 8'h09;
	localparam logic [7:0] IDX_RING_WIRE   = 8'h0a;
	localparam logic [7:0] IDX_MEM_SIZE    = 8'h0c;
	localparam logic [7:0] IDX_SAVED_SR    = 8'h10;
	localparam logic [7:0] IDX_SAVED_PC    = 8'h11;
	localparam logic [7:0] IDX_SAVED_SP    = 8'h12;
	localparam logic [7:0] IDX_THREAD_SEL  = 8'h13;
	localparam logic [7:0] IDX_REG_SEL     = 8'h14;
	localparam logic [7:0] IDX_ENTRY_CAUSE = 8'h15;
	localparam logic [7:0] IDX_DEBUG_DATA  = 8'h16;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	localparam int OSC_W            = 16;
	localparam int SSR_W            = 11;
	localparam int SSR_RSVD_BIT     = 5;
	localparam int SSR_DI_BIT       = 8;
	localparam int THREAD_W         = 8;
	localparam int REGSEL_W         = 5;
	localparam int CAUSE_W          = 3;
	localparam int CAUSE_THREAD_LSB = 8;
	localparam int BKPT_IDX_LSB     = 16;
	localparam int BKPT_IDX_W       = 2;
	localparam int NUM_BKPT         = 4;
	localparam int MEMSZ_LSB        = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Debug entry cause codes
	typedef enum logic [2:0] {
		CAUSE_NONE   = 3'h0,
		CAUSE_HOST   = 3'h1,
		CAUSE_DEBUG_CALL_INSTRUCTION  = 3'h2,
		CAUSE_IBRK   = 3'h3,
		CAUSE_DWATCH = 3'h4,
		CAUSE_RWATCH = 3'h5
	} dsc_cause_type;

	// Register-read instruction sequencer, one-hot
	typedef enum logic [1:0] {
		GR_IDLE = 2'b01,
		GR_WAIT = 2'b10
	} dsc_gr_state_type;

endpackage

// [hw/dsc_osc_count.sv]
// Ring oscillator edge counter that survives system reset
`timescale 1ns/1ps
`default_nettype none

module dsc_osc_count #(
	parameter int WIDTH = dsc_pkg::OSC_W
) (
	input  wire logic             i_clock,
	input  wire logic             i_por_b,
	input  wire logic             i_osc_pin,
	output logic [WIDTH-1:0]      o_count
);

	logic             sync1_ff;
	logic             sync2_ff;
	logic             last_ff;
	logic [WIDTH-1:0] count_ff;

	// ------------------------------------------------------------
	// Synchroniser and edge history
	// ------------------------------------------------------------
	// Oscillator is asynchronous to the core clock
	always_ff @(posedge i_clock) begin
		if (!i_por_b) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			last_ff  <= 1'b0;
		end else begin
			sync1_ff <= i_osc_pin;
			sync2_ff <= sync1_ff;
			last_ff  <= sync2_ff;
		end
	end

	// Only power-on clears the count; system reset is not wired here
	always_ff @(posedge i_clock) begin
		if (!i_por_b) begin
			count_ff <= '0;
		end else if (sync2_ff && !last_ff) begin
			count_ff <= count_ff + WIDTH'(1);
		end
	end

	assign o_count = count_ff;

endmodule
`default_nettype wire

// [bench/dsc_core_model.sv]
// Behavioural core that answers register-read fetch requests
`timescale 1ns/1ps
`default_nettype none
module dsc_core_model (
	input  wire logic       i_clock,
	input  wire logic       i_req,
	input  wire logic [7:0] i_thread,
	input  wire logic [4:0] i_reg,
	input  wire logic [1:0] i_delay,
	output logic            o_ack,
	output logic [31:0]     o_data
);
	logic       busy_ff = 1'b0;
	logic [1:0] wait_ff = 2'h0;
	initial o_ack = 1'b0;
	initial o_data = 32'h0;

	// answer fetch request
	// Idle data toggles so a stale word never passes for an answer
	always @(posedge i_clock) begin
		o_ack <= !i_req && busy_ff && wait_ff == 2'h0;
		o_data <= (!i_req && busy_ff && wait_ff == 2'h0) ? {i_thread, 11'h5a3, i_reg, 8'h3c} : ~o_data;
		if (i_req) begin
			busy_ff <= 1'b1;
			wait_ff <= i_delay;
		end else if (busy_ff && wait_ff != 2'h0) begin
			wait_ff <= wait_ff - 2'h1;
		end else if (busy_ff) begin
			busy_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [bench/dsc_regs_asserts.sv]
// Concurrent checks on the debug state capture register group
`timescale 1ns/1ps
`default_nettype none
module dsc_regs_asserts #(
	parameter int          ADDR_W         = 10,
	parameter logic [31:0] MEM_SIZE_BYTES = 32'h0001_0000
) (
	input wire logic              I_CLOCK,
	input wire logic              I_RST_B,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [31:0]       I_WDATA,
	input wire logic              I_WR,
	input wire logic              I_RD,
	input wire logic [31:0]       O_RDATA,
	input wire logic              I_DEBUG_MODE,
	input wire logic              I_DEBUG_ENTRY,
	input wire logic [31:0]       I_SAVED_PC,
	input wire logic [31:0]       I_SAVED_SP,
	input wire logic              I_HOST_REQ,
	input wire logic              I_GETREG_EXEC,
	input wire logic              I_GETREG_ACK,
	input wire logic [31:0]       I_GETREG_DATA,
	input wire logic              O_GETREG_REQ,
	input wire logic [7:0]        O_GETREG_THREAD,
	input wire logic [4:0]        O_GETREG_REG,
	input wire logic              O_GETREG_DONE,
	input wire logic [31:0]       O_GETREG_RESULT
);
	logic wait_ff;

	// Mirror of the fetch sequencer, so acks while idle are not counted
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_B) wait_ff <= 1'b0;
		else if (I_GETREG_EXEC && !wait_ff) wait_ff <= 1'b1;
		else if (I_GETREG_ACK && wait_ff) wait_ff <= 1'b0;
	end

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_B);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	sequence s_rd(a);
		I_RD && I_ADDR == a;
	endsequence
	sequence s_entry_rd(a);
		I_DEBUG_ENTRY ##1 s_rd(a);
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_cell_rsvd_zero: assert property (s_rd(10'h024) |=> O_RDATA[31:16] == 16'h0000)
		else $error("cell count upper half not zero");
	a_wire_rsvd_zero: assert property (s_rd(10'h028) |=> O_RDATA[31:16] == 16'h0000)
		else $error("wire count upper half not zero");
	a_mem_size_word: assert property (s_rd(10'h030) |=> O_RDATA == {MEM_SIZE_BYTES[31:2], 2'b00})
		else $error("memory size word wrong");
	a_status_rsvd_bits: assert property (s_rd(10'h040) |=> O_RDATA[31:11] == 21'h0 && !O_RDATA[5])
		else $error("status reserved bits set");
	a_pc_capture: assert property (s_entry_rd(10'h044) |=> O_RDATA == $past(I_SAVED_PC, 2))
		else $error("saved pc not captured");
	a_sp_capture: assert property (s_entry_rd(10'h048) |=> O_RDATA == $past(I_SAVED_SP, 2))
		else $error("saved sp not captured");
	a_host_cause_word: assert property ((I_HOST_REQ && I_DEBUG_ENTRY) ##1 s_rd(10'h054) |=> O_RDATA == 32'h1)
		else $error("host cause word wrong");
	a_thread_sel_write: assert property (I_WR && I_DEBUG_MODE && I_ADDR == 10'h04c
		|=> {24'h0, O_GETREG_THREAD} == ($past(I_WDATA) & 32'hff))
		else $error("thread select not written");
	a_reg_sel_write: assert property (I_WR && I_DEBUG_MODE && I_ADDR == 10'h050
		|=> {27'h0, O_GETREG_REG} == ($past(I_WDATA) & 32'h1f))
		else $error("register select not written");
	a_write_locked_out: assert property (I_WR && !I_DEBUG_MODE |=> $stable(O_GETREG_THREAD) && $stable(O_GETREG_REG))
		else $error("write taken outside debug mode");
	a_getreg_request: assert property (I_GETREG_EXEC && !wait_ff |=> O_GETREG_REQ)
		else $error("fetch request missing");
	a_getreg_result: assert property (I_GETREG_ACK && wait_ff |=> O_GETREG_DONE && O_GETREG_RESULT == $past(I_GETREG_DATA))
		else $error("fetch result wrong");
endmodule

bind dsc_regs dsc_regs_asserts #(.ADDR_W(ADDR_W), .MEM_SIZE_BYTES(MEM_SIZE_BYTES)) u_dsc_chk (
	.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
	.O_RDATA(O_RDATA), .I_DEBUG_MODE(I_DEBUG_MODE), .I_DEBUG_ENTRY(I_DEBUG_ENTRY), .I_SAVED_PC(I_SAVED_PC),
	.I_SAVED_SP(I_SAVED_SP), .I_HOST_REQ(I_HOST_REQ), .I_GETREG_EXEC(I_GETREG_EXEC), .I_GETREG_ACK(I_GETREG_ACK),
	.I_GETREG_DATA(I_GETREG_DATA), .O_GETREG_REQ(O_GETREG_REQ), .O_GETREG_THREAD(O_GETREG_THREAD),
	.O_GETREG_REG(O_GETREG_REG), .O_GETREG_DONE(O_GETREG_DONE), .O_GETREG_RESULT(O_GETREG_RESULT)
);
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the debug state capture register group
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
	// Low address bits set on purpose: they must read back as zero
	localparam logic [31:0] MEM = 32'h0002_4007;
	logic        I_CLOCK, I_RST_B, I_POR_B, I_WR, I_RD, I_OSC_CELL, I_OSC_WIRE, I_DEBUG_MODE, I_DEBUG_ENTRY;
	logic        I_HOST_REQ, I_DEBUG_CALL_INSTRUCTION, I_GETREG_EXEC, I_GETREG_ACK, O_GETREG_REQ, O_GETREG_DONE;
	logic [9:0]  I_ADDR;
	logic [10:0] I_SAVED_STATUS, e_ss;
	logic [31:0] I_WDATA, O_RDATA, I_SAVED_PC, I_SAVED_SP, I_WATCH_ADDR, I_RESOURCE_ID, I_GETREG_DATA;
	logic [31:0] O_GETREG_RESULT, e_cause, e_data, e_pc, e_sp, v;
	logic [3:0]  I_IBRK_HIT, I_DWATCH_HIT, I_RWATCH_HIT;
	logic [7:0]  I_CAUSE_THREAD, O_GETREG_THREAD;
	logic [4:0]  O_GETREG_REG;
	logic [1:0]  dly;
	int          seed = 52, n_fail = 0, num_checks = 0, n1, n2, i;

	dsc_regs #(.ADDR_W(10), .MEM_SIZE_BYTES(MEM)) dut (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_POR_B(I_POR_B),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_OSC_CELL(I_OSC_CELL),
		.I_OSC_WIRE(I_OSC_WIRE), .I_DEBUG_MODE(I_DEBUG_MODE), .I_DEBUG_ENTRY(I_DEBUG_ENTRY),
		.I_SAVED_STATUS(I_SAVED_STATUS), .I_SAVED_PC(I_SAVED_PC), .I_SAVED_SP(I_SAVED_SP), .I_HOST_REQ(I_HOST_REQ),
		.I_DEBUG_CALL_INSTRUCTION(I_DEBUG_CALL_INSTRUCTION), .I_IBRK_HIT(I_IBRK_HIT), .I_DWATCH_HIT(I_DWATCH_HIT), .I_RWATCH_HIT(I_RWATCH_HIT),
		.I_CAUSE_THREAD(I_CAUSE_THREAD), .I_WATCH_ADDR(I_WATCH_ADDR), .I_RESOURCE_ID(I_RESOURCE_ID),
		.I_GETREG_EXEC(I_GETREG_EXEC), .I_GETREG_ACK(I_GETREG_ACK), .I_GETREG_DATA(I_GETREG_DATA),
		.O_GETREG_REQ(O_GETREG_REQ), .O_GETREG_THREAD(O_GETREG_THREAD), .O_GETREG_REG(O_GETREG_REG),
		.O_GETREG_DONE(O_GETREG_DONE), .O_GETREG_RESULT(O_GETREG_RESULT));
	dsc_core_model u_core (.i_clock(I_CLOCK), .i_req(O_GETREG_REQ), .i_thread(O_GETREG_THREAD),
		.i_reg(O_GETREG_REG), .i_delay(dly), .o_ack(I_GETREG_ACK), .o_data(I_GETREG_DATA));

	always #20 I_CLOCK = ~I_CLOCK;

	// ------------------------------------------------------------
	// Bus tasks and expectations
	// ------------------------------------------------------------
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge I_CLOCK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLOCK);
		I_WR <= 1'b0;
	endtask
	// Read also ends any entry pulse, so capture and read run back to back
	task automatic rc(input logic [9:0] a, input logic [31:0] e, input string nm);
		@(posedge I_CLOCK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		I_DEBUG_ENTRY <= 1'b0;
		@(posedge I_CLOCK);
		I_RD <= 1'b0;
		@(negedge I_CLOCK);
		`CHK(nm, e, O_RDATA)
	endtask
	function automatic logic [31:0] exp_cause(input int k, input logic [3:0] h, input logic [7:0] t);
		logic [1:0] ix;
		ix = h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : 2'h3;
		if (k == 1) return 32'h1;
		if (k == 2) return {16'h0, t, 8'h02};
		return {14'h0, ix, t, 5'h0, 3'(k)};
	endfunction
	// One debug entry of cause kind k with random saved state
	task automatic ent(input int k);
		logic [3:0] h;
		h = 4'($random(seed)) | 4'h8;
		v = $random(seed);
		e_pc = $random(seed);
		e_sp = $random(seed);
		e_ss = 11'($random(seed));
		@(posedge I_CLOCK);
		I_DEBUG_ENTRY <= 1'b1;
		I_SAVED_STATUS <= e_ss;
		I_SAVED_PC <= e_pc;
		I_SAVED_SP <= e_sp;
		I_CAUSE_THREAD <= v[15:8];
		I_WATCH_ADDR <= v;
		I_RESOURCE_ID <= ~v;
		I_HOST_REQ <= (k == 1);
		I_DEBUG_CALL_INSTRUCTION <= (k == 2);
		I_IBRK_HIT <= (k <= 3) ? h : 4'h0;
		I_DWATCH_HIT <= (k == 4) ? h : 4'h0;
		I_RWATCH_HIT <= (k == 5) ? h : 4'h0;
		e_ss[5] = 1'b0;
		e_cause = exp_cause(k, h, v[15:8]);
		if (k == 4) e_data = v;
		if (k == 5) e_data = ~v;
	endtask
	task automatic osc(input int n, input bit w);
		repeat (n) begin
			@(posedge I_CLOCK);
			{I_OSC_WIRE, I_OSC_CELL} <= w ? 2'b10 : 2'b01;
			repeat (3) @(posedge I_CLOCK);
			{I_OSC_WIRE, I_OSC_CELL} <= 2'b00;
			repeat (2) @(posedge I_CLOCK);
		end
		repeat (12) @(posedge I_CLOCK);
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{I_CLOCK, I_RST_B, I_POR_B, I_WR, I_RD, I_OSC_CELL, I_OSC_WIRE, I_DEBUG_MODE, I_DEBUG_ENTRY, I_HOST_REQ,
			I_DEBUG_CALL_INSTRUCTION, I_GETREG_EXEC, I_ADDR, I_WDATA, I_SAVED_STATUS, I_SAVED_PC, I_SAVED_SP, I_IBRK_HIT,
			I_DWATCH_HIT, I_RWATCH_HIT, I_CAUSE_THREAD, I_WATCH_ADDR, I_RESOURCE_ID, dly, e_data} = '0;
		repeat (10) @(posedge I_CLOCK);
		I_RST_B <= 1'b1;
		I_POR_B <= 1'b1;
		rc(10'h054, 32'h0, "cause after reset");
		rc(10'h030, {MEM[31:2], 2'b00}, "memory size");
		rc(10'h03c, 32'h0, "unmapped word");
		rc(10'h041, 32'h0, "misaligned word");
		n1 = 3 + ($random(seed) & 15);
		n2 = 3 + ($random(seed) & 15);
		osc(n1, 1'b0);
		osc(n2, 1'b1);
		rc(10'h024, 32'(n1), "cell count");
		rc(10'h028, 32'(n2), "wire count");
		@(posedge I_CLOCK);
		I_RST_B <= 1'b0;
		repeat (2) @(posedge I_CLOCK);
		I_RST_B <= 1'b1;
		rc(10'h024, 32'(n1), "cell after reset");
		rc(10'h028, 32'(n2), "wire after reset");
		@(posedge I_CLOCK);
		I_POR_B <= 1'b0;
		repeat (2) @(posedge I_CLOCK);
		I_POR_B <= 1'b1;
		rc(10'h028, 32'h0, "wire after power on");
		for (int k = 1; k <= 5; k++) begin
			ent(k);
			rc(10'h054, e_cause, "cause word");
			rc(10'h058, e_data, "debug data");
			rc(10'h040, {21'h0, e_ss}, "saved status");
			rc(10'h044, e_pc, "saved pc");
			rc(10'h048, e_sp, "saved sp");
		end
		ent(3);
		rc(10'h044, e_pc, "pc after entry");
		ent(4);
		rc(10'h048, e_sp, "sp after entry");
		wr(10'h044, ~e_pc);
		wr(10'h04c, 32'h0000_00a5);
		rc(10'h044, e_pc, "pc write locked");
		@(posedge I_CLOCK);
		I_DEBUG_MODE <= 1'b1;
		wr(10'h044, ~e_pc);
		rc(10'h044, ~e_pc, "pc debug write");
		wr(10'h058, e_sp);
		rc(10'h058, e_sp, "data debug write");
		wr(10'h054, 32'hffff_ffff);
		rc(10'h054, 32'h0003_ff07, "cause write");
		wr(10'h040, 32'hffff_ffff);
		rc(10'h040, {21'h0, 11'h6df | (e_ss & 11'h100)}, "status write");
		wr(10'h024, 32'hffff_ffff);
		wr(10'h030, 32'h0);
		rc(10'h024, 32'h0, "cell read only");
		rc(10'h030, {MEM[31:2], 2'b00}, "memory read only");
		// Fetches with the core answering promptly and slowly
		repeat (8) begin
			v = $random(seed);
			dly <= v[9:8];
			wr(10'h04c, v);
			wr(10'h050, ~v);
			rc(10'h04c, v & 32'hff, "thread select");
			rc(10'h050, ~v & 32'h1f, "register select");
			@(posedge I_CLOCK);
			I_GETREG_EXEC <= 1'b1;
			@(posedge I_CLOCK);
			I_GETREG_EXEC <= 1'b0;
			i = 0;
			do begin
				@(negedge I_CLOCK);
				i++;
			end while (O_GETREG_DONE !== 1'b1 && i < 20);
			`CHK("fetch done", 1'b1, O_GETREG_DONE)
			`CHK("fetch result", {v[7:0], 11'h5a3, ~v[4:0], 8'h3c}, O_GETREG_RESULT)
		end
		end_of_test;
	end

	// Hang guard, well past the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge I_CLOCK);
		n_fail++;
		end_of_test;
	end
endmodule
`default_nettype wire
